/* File: hw/aonldo_config_regs.v */
// config registers and control decode of the always-on linear regulator
//
// Behaviour
// - supply bit selects external or internal input
// - discharge bit zero: discharge in hard reset only
// - discharge bit one: also discharge on enable fall
// - mode bit zero regulates, one is switch
// - switch mode: pass device follows enable, unregulated
// - mode latched, changes only while regulator disabled
// - enable field governs only under sequence 111
// - pin control: or of selected pins
//
// notes for users
// pin levels are taken as already synchronous
// register bus is plain strobes, no wait states
// read data answers one cycle after the strobe
// passive discharge only handed on as stored bit
// voltage code is a request; input supply limits it
// enable-fall discharge is a single-cycle pulse
// reserved enable field code behaves as off
// outside software sequence the sequencer enable rules
// mode write while enabled is held, not lost
// mode latch is a flop fed by an open-when-low mux
// no interrupt or status of its own
`timescale 1ns/10ps
`default_nettype none
`include "aonldo_regs.vh"
module aonldo_config_regs #(
  parameter NPIN = 8
) (
  // clock and reset
  input  wire            CLOCK,
  input  wire            NRST,
  // register port
  input  wire [7:0]      REG_ADDR,
  input  wire [7:0]      REG_WDATA,
  input  wire            REG_WR,
  input  wire            REG_RD,
  output reg  [7:0]      REG_RDATA,
  output reg             REG_RD_HIT,
  // enable and sequence from the enable register
  input  wire [2:0]      BOOT_SEQUENCE_CODE,
  input  wire [1:0]      REGULATOR_ENABLE_FIELD,
  input  wire            SEQ_ENABLE,
  input  wire            HARD_RESET_MODE,
  // multipurpose pins
  input  wire [NPIN-1:0] MULTIPURPOSE_PIN,
  // analog controls
  output reg             EFFECTIVE_ENABLE,
  output reg             INPUT_SOURCE_SELECT,
  output reg             SWITCH_MODE_ACTIVE,
  output reg             PASS_FULL_ON,
  output reg             REGULATION_ON,
  output reg             ACTIVE_DISCHARGE,
  output reg             PASSIVE_DISCHARGE_ON_DISABLE,
  output reg  [4:0]      OUTPUT_VOLTAGE_CODE,
  output reg  [15:0]     TARGET_MILLIVOLTS
);
  // stored register fields
  reg  [3:0]      config_q;      // supply, actdsc, mode, psvdsc
  reg  [4:0]      vcode_q;       // output voltage code
  reg  [NPIN-1:0] pinsel_q;      // pin enable select byte
  reg             mode_lat_q;    // latched switch mode
  reg             en_prev_q;     // enable one cycle ago
  // decode results
  reg             en_d;          // enable next value
  reg             dsc_d;         // discharge next value
  wire            pin_any;       // or of selected pins
  wire            en_fall;       // enable falling this cycle
  wire            mode_d;        // latched mode next value

  // register address match
  // shared by write and read decode
  function hit;
    input [7:0] a;
    input [7:0] ofs;
    begin
      hit = (a == ofs);
    end
  endfunction

  // pin or network
  // select byte gates each pin, then all are or-ed
  aonldo_pin_or #(.NPIN(NPIN)) u_pin_or (
    .sel    (pinsel_q),
    .pins   (MULTIPURPOSE_PIN),
    .any_on (pin_any)
  );

  // effective enable from sequence and field
  // combinational so the mode latch and the fall
  // detector see the new enable in the same cycle
  // reserved field code falls to off, never on
  // sequencer enable is used as given
  always @* begin
    if (BOOT_SEQUENCE_CODE == `AONLDO_SEQ_SW) begin
      case (REGULATOR_ENABLE_FIELD)
        `AONLDO_EN_ON:  en_d = 1'b1;
        `AONLDO_EN_PIN: en_d = pin_any;
        default:        en_d = 1'b0;                 // off and reserved
      endcase
    end else begin
      en_d = SEQ_ENABLE;  // boot sequencer decides
    end
  end

  // enable falls when it was on and goes off
  // previous enable is the registered one
  assign en_fall = en_prev_q & ~en_d;

  // mode follows register only while disabled
  // latch is open while the enable is low, so a write
  // made while enabled waits for the next disable
  // keeps the pass device from changing mode under load
  assign mode_d = en_d ? mode_lat_q
                       : config_q[`AONLDO_BIT_MODE];

  // discharge policy
  // hard reset always discharges
  // enable fall adds a one-cycle pulse when bit two set
  // pulse marks the fall; hold time is the analog side's
  always @* begin
    dsc_d = HARD_RESET_MODE;
    if (config_q[`AONLDO_BIT_ACTDSC] && en_fall) begin
      dsc_d = 1'b1;
    end
  end

  // register writes
  // unmapped offsets and unused upper bits are dropped
  // a write and a read in one cycle read the old value
  // pin select width follows NPIN
  always @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      // all fields clear
      config_q <= 4'h0;
      vcode_q  <= 5'h00;
      pinsel_q <= {NPIN{1'b0}};
    end else if (REG_WR) begin
      if (hit(REG_ADDR, `AONLDO_OFS_CONFIG)) begin
        config_q <= REG_WDATA[3:0];
      end
      if (hit(REG_ADDR, `AONLDO_OFS_VOLTAGE)) begin
        vcode_q <= REG_WDATA[4:0];
      end
      if (hit(REG_ADDR, `AONLDO_OFS_PINSEL)) begin
        pinsel_q <= REG_WDATA[NPIN-1:0];
      end
    end
  end

  // registered read data, unused bits zero
  // data and hit stand for one cycle only
  // zero between reads keeps the bus quiet
  // mapped offsets raise the hit flag
  always @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      REG_RDATA  <= 8'h00;
      REG_RD_HIT <= 1'b0;
    end else begin
      REG_RDATA  <= 8'h00;
      REG_RD_HIT <= 1'b0;
      // default quiet unless a mapped read
      if (REG_RD) begin
        if (hit(REG_ADDR, `AONLDO_OFS_CONFIG)) begin
          REG_RDATA  <= {4'h0, config_q};
          REG_RD_HIT <= 1'b1;
        end else if (hit(REG_ADDR, `AONLDO_OFS_VOLTAGE)) begin
          REG_RDATA  <= {3'h0, vcode_q};
          REG_RD_HIT <= 1'b1;
        end else if (hit(REG_ADDR, `AONLDO_OFS_PINSEL)) begin
          REG_RDATA  <= pinsel_q;
          REG_RD_HIT <= 1'b1;
        end
      end
    end
  end

  // latched mode and enable history
  // enable history feeds the fall detector
  // both clear in reset, so no false fall follows
  always @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      mode_lat_q <= 1'b0;
      en_prev_q  <= 1'b0;
    end else begin
      mode_lat_q <= mode_d;
      en_prev_q  <= en_d;
    end
  end

  // analog control outputs
  // all registered so the analog side sees clean levels
  // one cycle after the inputs or registers change
  // millivolt target reset matches code zero
  // pass and regulation are never on together
  // supply and passive bits pass straight through
  always @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      EFFECTIVE_ENABLE             <= 1'b0;
      INPUT_SOURCE_SELECT          <= 1'b0;
      SWITCH_MODE_ACTIVE           <= 1'b0;
      PASS_FULL_ON                 <= 1'b0;
      REGULATION_ON                <= 1'b0;
      ACTIVE_DISCHARGE             <= 1'b0;
      PASSIVE_DISCHARGE_ON_DISABLE <= 1'b0;
      OUTPUT_VOLTAGE_CODE          <= 5'h00;
      TARGET_MILLIVOLTS            <= `AONLDO_MV_BASE;
    end else begin
      // follow decode one cycle later
      EFFECTIVE_ENABLE    <= en_d;
      INPUT_SOURCE_SELECT <= config_q[`AONLDO_BIT_SUPPLY];
      SWITCH_MODE_ACTIVE  <= mode_d;
      PASS_FULL_ON        <= mode_d & en_d;
      REGULATION_ON       <= ~mode_d & en_d;
      ACTIVE_DISCHARGE    <= dsc_d;
      PASSIVE_DISCHARGE_ON_DISABLE <= config_q[`AONLDO_BIT_PSVDSC];
      OUTPUT_VOLTAGE_CODE <= vcode_q;
      // linear map, code 31 gives 4000 mV
      TARGET_MILLIVOLTS   <= `AONLDO_MV_BASE
                           + (`AONLDO_MV_STEP * {11'h000, vcode_q});
    end
  end
endmodule
`default_nettype wire

/* File: pkg/aonldo_regs.vh */
// register offsets, field positions and reset values of the always-on ldo
`ifndef AONLDO_REGS_VH
`define AONLDO_REGS_VH
// register offsets on the configuration port
`define AONLDO_OFS_CONFIG      8'h56
`define AONLDO_OFS_VOLTAGE     8'h57
`define AONLDO_OFS_PINSEL      8'h58
// config register field positions
`define AONLDO_BIT_SUPPLY      3
`define AONLDO_BIT_ACTDSC      2
`define AONLDO_BIT_MODE        1
`define AONLDO_BIT_PSVDSC      0
// config register writable mask
`define AONLDO_CONFIG_MASK     8'h0f
// voltage code width and writable mask
`define AONLDO_VCODE_W         5
`define AONLDO_VCODE_MASK      8'h1f
// reset values
`define AONLDO_RST_CONFIG      8'h00
`define AONLDO_RST_VOLTAGE     8'h00
`define AONLDO_RST_PINSEL      8'h00
// boot sequence code under which the enable field governs
`define AONLDO_SEQ_SW          3'h7
// enable field encodings
`define AONLDO_EN_OFF          2'h0
`define AONLDO_EN_ON           2'h1
`define AONLDO_EN_PIN          2'h2
`define AONLDO_EN_RSVD         2'h3
// voltage code map: millivolts at code zero and per step
`define AONLDO_MV_BASE         16'd900
`define AONLDO_MV_STEP         16'd100
`endif

/* File: hw/aonldo_pin_or.v */
// or of the multipurpose pins whose select bit is set
`timescale 1ns/10ps
`default_nettype none
module aonldo_pin_or #(
  parameter NPIN = 8
) (
  // select byte and pin levels
  input  wire [NPIN-1:0] sel,
  input  wire [NPIN-1:0] pins,
  // combined enable request
  output wire            any_on
);
  wire [NPIN-1:0] gated;  // per pin gated level

  // bit n of the select byte gates pin n
  genvar n;
  generate
    for (n = 0; n < NPIN; n = n + 1) begin : g_gate
      assign gated[n] = sel[n] & pins[n];
    end
  endgenerate

  // any selected pin high enables
  assign any_on = |gated;
endmodule
`default_nettype wire

/* File: dv/aonldo_sva.sv */
// port assertions for the always-on ldo register block
`timescale 1ns/10ps
`default_nettype none
module aonldo_sva #(
  parameter NPIN = 8
) (
  // clock, reset, write strobe
  input wire logic            CLOCK,
  input wire logic            NRST,
  input wire logic            REG_WR,
  // enable sources
  input wire logic [2:0]      BOOT_SEQUENCE_CODE,
  input wire logic [1:0]      REGULATOR_ENABLE_FIELD,
  input wire logic            SEQ_ENABLE,
  input wire logic            HARD_RESET_MODE,
  input wire logic [NPIN-1:0] MULTIPURPOSE_PIN,
  // analog controls
  input wire logic            EFFECTIVE_ENABLE,
  input wire logic            SWITCH_MODE_ACTIVE,
  input wire logic            INPUT_SOURCE_SELECT,
  input wire logic            ACTIVE_DISCHARGE,
  input wire logic [4:0]      OUTPUT_VOLTAGE_CODE,
  input wire logic [15:0]     TARGET_MILLIVOLTS
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!NRST);
  // two quiet cycles on the write strobe
  sequence s_no_wr2; !REG_WR ##1 !REG_WR; endsequence
  property p_seq_en; BOOT_SEQUENCE_CODE != 3'h7
    |=> EFFECTIVE_ENABLE == $past(SEQ_ENABLE); endproperty
  property p_field;
    BOOT_SEQUENCE_CODE == 3'h7 && REGULATOR_ENABLE_FIELD != 2'h2
    |=> EFFECTIVE_ENABLE == ($past(REGULATOR_ENABLE_FIELD) == 2'h1);
  endproperty
  property p_pin; BOOT_SEQUENCE_CODE == 3'h7 && REGULATOR_ENABLE_FIELD == 2'h2
    && MULTIPURPOSE_PIN == 0 |=> !EFFECTIVE_ENABLE; endproperty
  property p_hard; HARD_RESET_MODE |=> ACTIVE_DISCHARGE; endproperty
  property p_mv;
    TARGET_MILLIVOLTS == 16'h384 + 16'h64 * OUTPUT_VOLTAGE_CODE; endproperty
  property p_mode; $changed(SWITCH_MODE_ACTIVE)
    |-> !EFFECTIVE_ENABLE || !$past(EFFECTIVE_ENABLE); endproperty
  property p_src; s_no_wr2 |=> $stable(INPUT_SOURCE_SELECT); endproperty
  property p_volt; s_no_wr2 |=> $stable(OUTPUT_VOLTAGE_CODE); endproperty
  a_seq_en: assert property (p_seq_en) else $error("seq enable");
  a_field: assert property (p_field) else $error("enable field");
  a_pin: assert property (p_pin) else $error("pin enable");
  a_hard: assert property (p_hard) else $error("hard discharge");
  a_mv: assert property (p_mv) else $error("millivolts");
  a_mode: assert property (p_mode) else $error("mode latch");
  a_src: assert property (p_src) else $error("supply bit");
  a_volt: assert property (p_volt) else $error("voltage code");
endmodule
bind aonldo_config_regs aonldo_sva #(.NPIN(NPIN)) i_sva (
  .CLOCK                  (CLOCK),
  .NRST                   (NRST),
  .REG_WR                 (REG_WR),
  .BOOT_SEQUENCE_CODE     (BOOT_SEQUENCE_CODE),
  .REGULATOR_ENABLE_FIELD (REGULATOR_ENABLE_FIELD),
  .SEQ_ENABLE             (SEQ_ENABLE),
  .HARD_RESET_MODE        (HARD_RESET_MODE),
  .MULTIPURPOSE_PIN       (MULTIPURPOSE_PIN),
  .EFFECTIVE_ENABLE       (EFFECTIVE_ENABLE),
  .SWITCH_MODE_ACTIVE     (SWITCH_MODE_ACTIVE),
  .INPUT_SOURCE_SELECT    (INPUT_SOURCE_SELECT),
  .ACTIVE_DISCHARGE       (ACTIVE_DISCHARGE),
  .OUTPUT_VOLTAGE_CODE    (OUTPUT_VOLTAGE_CODE),
  .TARGET_MILLIVOLTS      (TARGET_MILLIVOLTS)
);
`default_nettype wire

/* File: dv/aon_ldo_config_regs_test.sv */
// self-checking bench for the always-on ldo register block
`timescale 1ns/10ps
`default_nettype none
module aon_ldo_config_regs_test;
  // stimulus, named as the dut ports
  logic        CLOCK = 0, NRST = 0, REG_WR = 0, REG_RD = 0, SEQ_ENABLE = 0;
  logic        HARD_RESET_MODE = 0, rd_q = 0, REG_RD_HIT, EFFECTIVE_ENABLE;
  logic [7:0]  REG_ADDR = 0, REG_WDATA = 0, MULTIPURPOSE_PIN = 0, REG_RDATA;
  logic [2:0]  BOOT_SEQUENCE_CODE = 3'h7;
  logic [1:0]  REGULATOR_ENABLE_FIELD = 0;
  logic        INPUT_SOURCE_SELECT, SWITCH_MODE_ACTIVE, PASS_FULL_ON;
  logic        REGULATION_ON, ACTIVE_DISCHARGE, PASSIVE_DISCHARGE_ON_DISABLE;
  logic [4:0]  OUTPUT_VOLTAGE_CODE;
  logic [15:0] TARGET_MILLIVOLTS;
  logic [8:0]  exp_q[$];
  logic [7:0]  v, s;
  int          errors = 0, n_tests = 0, i;
  aonldo_config_regs #(.NPIN(8)) i_dut (
    .CLOCK                        (CLOCK),
    .NRST                         (NRST),
    .REG_ADDR                     (REG_ADDR),
    .REG_WDATA                    (REG_WDATA),
    .REG_WR                       (REG_WR),
    .REG_RD                       (REG_RD),
    .REG_RDATA                    (REG_RDATA),
    .REG_RD_HIT                   (REG_RD_HIT),
    .BOOT_SEQUENCE_CODE           (BOOT_SEQUENCE_CODE),
    .REGULATOR_ENABLE_FIELD       (REGULATOR_ENABLE_FIELD),
    .SEQ_ENABLE                   (SEQ_ENABLE),
    .HARD_RESET_MODE              (HARD_RESET_MODE),
    .MULTIPURPOSE_PIN             (MULTIPURPOSE_PIN),
    .EFFECTIVE_ENABLE             (EFFECTIVE_ENABLE),
    .INPUT_SOURCE_SELECT          (INPUT_SOURCE_SELECT),
    .SWITCH_MODE_ACTIVE           (SWITCH_MODE_ACTIVE),
    .PASS_FULL_ON                 (PASS_FULL_ON),
    .REGULATION_ON                (REGULATION_ON),
    .ACTIVE_DISCHARGE             (ACTIVE_DISCHARGE),
    .PASSIVE_DISCHARGE_ON_DISABLE (PASSIVE_DISCHARGE_ON_DISABLE),
    .OUTPUT_VOLTAGE_CODE          (OUTPUT_VOLTAGE_CODE),
    .TARGET_MILLIVOLTS            (TARGET_MILLIVOLTS)
  );
  always #12.5 CLOCK = ~CLOCK;
  // compare one value
  task chk(string n, logic [15:0] e, logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask
  // compare one read byte with its hit flag on top
  task chk_rd(logic [8:0] e, logic [8:0] g);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH rdata exp %h got %h", e, g);
    end
  endtask
  task wr(logic [7:0] a, logic [7:0] d);
    @(negedge CLOCK) {REG_WR, REG_ADDR, REG_WDATA} = {1'b1, a, d};
    @(negedge CLOCK) REG_WR = 0;
  endtask
  task rd(logic [7:0] a, logic [7:0] e);
    exp_q.push_back({a >= 8'h56 && a <= 8'h58, e});
    @(negedge CLOCK) {REG_RD, REG_ADDR} = {1'b1, a};
    @(negedge CLOCK) REG_RD = 0;
  endtask
  task step;
    repeat (3) @(negedge CLOCK);
  endtask
  task count_dsc;
    v = 0;
    repeat (4) @(negedge CLOCK) v += ACTIVE_DISCHARGE;
  endtask
  task complete_run;
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // read watcher: oldest note against returned byte
  always @(posedge CLOCK) rd_q <= REG_RD;
  always @(negedge CLOCK)
    if (rd_q) chk_rd(exp_q.pop_front(), {REG_RD_HIT, REG_RDATA});
  // watchdog
  initial begin
    #200000;
    errors++;
    complete_run;
  end
  initial begin
    void'($urandom(32'h8bd9));
    repeat (4) @(negedge CLOCK);
    NRST = 1;
    chk("mv", 16'h384, TARGET_MILLIVOLTS);
    for (i = 0; i < 4; i++) rd(8'h56 + i, 8'h00);
    wr(8'h56, 8'hfd);
    rd(8'h56, 8'h0d);
    step;
    chk("src", 1, INPUT_SOURCE_SELECT);
    chk("psv", 1, PASSIVE_DISCHARGE_ON_DISABLE);
    for (i = 0; i < 4; i++) begin
      v = (i == 0) ? 8'h00 : (i == 1) ? 8'h1f : $urandom % 32;
      wr(8'h57, v | 8'he0);
      rd(8'h57, v);
      step;
      chk("mv", 16'h384 + 16'h64 * v, TARGET_MILLIVOLTS);
      chk("code", v, OUTPUT_VOLTAGE_CODE);
    end
    $display("registers done");
    for (i = 0; i < 4; i++) begin
      REGULATOR_ENABLE_FIELD = i;
      step;
      chk("en", i == 1, EFFECTIVE_ENABLE);
    end
    BOOT_SEQUENCE_CODE = 3'h3;
    SEQ_ENABLE = 1;
    step;
    chk("en", 1, EFFECTIVE_ENABLE);
    BOOT_SEQUENCE_CODE = 3'h7;
    REGULATOR_ENABLE_FIELD = 2'h2;
    for (i = 0; i < 8; i++) begin
      s = $urandom;
      MULTIPURPOSE_PIN = $urandom;
      wr(8'h58, s);
      step;
      chk("pin", |(s & MULTIPURPOSE_PIN), EFFECTIVE_ENABLE);
    end
    $display("enable done");
    wr(8'h56, 8'h00);
    REGULATOR_ENABLE_FIELD = 0;
    step;
    REGULATOR_ENABLE_FIELD = 1;
    step;
    wr(8'h56, 8'h02);
    step;
    chk("mode", 0, SWITCH_MODE_ACTIVE);
    chk("reg", 1, REGULATION_ON);
    chk("src", 0, INPUT_SOURCE_SELECT);
    chk("psv", 0, PASSIVE_DISCHARGE_ON_DISABLE);
    REGULATOR_ENABLE_FIELD = 0;
    step;
    chk("mode", 1, SWITCH_MODE_ACTIVE);
    chk("pass", 0, PASS_FULL_ON);
    REGULATOR_ENABLE_FIELD = 1;
    step;
    chk("pass", 1, PASS_FULL_ON);
    chk("reg", 0, REGULATION_ON);
    $display("mode done");
    wr(8'h56, 8'h04);
    REGULATOR_ENABLE_FIELD = 0;
    count_dsc;
    chk("dsc", 1, v);
    wr(8'h56, 8'h00);
    REGULATOR_ENABLE_FIELD = 1;
    step;
    REGULATOR_ENABLE_FIELD = 0;
    count_dsc;
    chk("dsc", 0, v);
    HARD_RESET_MODE = 1;
    step;
    chk("dsc", 1, ACTIVE_DISCHARGE);
    $display("discharge done");
    complete_run;
  end
endmodule
`default_nettype wire
